// ### dma_req_params.svh
// Constants for the external request sampler: offsets, fields, widths and encodings.
`ifndef DMA_REQ_PARAMS_SVH
`define DMA_REQ_PARAMS_SVH
`define DRS_ADDR_W 4
`define DRS_CTRL_OFS 4'h0
`define DRS_STAT_OFS 4'h4
`define DRS_CTRL_EN_BIT 0
`define DRS_CTRL_MODE_LO 1
`define DRS_CTRL_MODE_HI 2
`define DRS_CTRL_FCS_BIT 3
`define DRS_MODE_EDGE 2'h0
`define DRS_MODE_FIFO16 2'h1
`define DRS_MODE_FIFO1 2'h2
`define DRS_STAT_PEND_BIT 8
`define DRS_STAT_ACK_BIT 9
`define DRS_CNT_W 24
`define DRS_FIFO_DEPTH 16
`define DRS_FCNT_W 5
`endif

// ### dma_req_pkg.sv
// Types shared by the external request sampler.
`include "dma_req_params.svh"
package dma_req_pkg;
   typedef enum logic [2:0] {
      MODE_EDGE = 3'b001,
      MODE_FIFO16 = 3'b010,
      MODE_FIFO1 = 3'b100
   } mode_t;
   typedef enum logic [2:0] {
      ACK_IDLE = 3'b001,
      ACK_ARMED = 3'b010,
      ACK_HIGH = 3'b100
   } ack_st_t;
   typedef struct packed {
      logic [1:0] clk_sync;
      logic [1:0] req_sync;
      logic clk_prev;
      logic [1:0] low_hist;
      logic enable;
      logic [1:0] mode_field;
      logic flag_clear_timing_select;
      logic [`DRS_CNT_W-1:0] pending;
      logic edge_first;
      logic [`DRS_FCNT_W-1:0] fifo_cnt;
      logic [`DRS_FCNT_W-1:0] ack_owe;
      ack_st_t ack_st;
      logic [31:0] rdata;
   } state_t;
endpackage : dma_req_pkg

// ### dma_external_request_sampler.sv
// Request pin sampler with noise canceler, edge and level modes, and ack strobe.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "dma_req_params.svh"
module dma_external_request_sampler #(
   parameter int FIFO_DEPTH = `DRS_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Register port
   input wire logic [`DRS_ADDR_W-1:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // External pins
   input wire logic EXT_BUS_CLK,
   input wire logic EXT_XFER_REQUEST_N,
   output logic REQUEST_ACK_STROBE,
   // Channel sequencer
   input wire logic [`DRS_CNT_W-1:0] TRANSFER_COUNT,
   output logic XFER_REQ,
   input wire logic XFER_CONFIRM
);
   dma_req_pkg::state_t q_ff;
   dma_req_pkg::state_t nxt_q;
   dma_req_pkg::mode_t mode;
   logic tick;
   logic low_now;
   logic level_ok;
   logic edge_det;
   logic grant;
   logic confirm;
   logic inc;
   logic dec;
   logic edge_start;
   logic ack_req;
   logic ack_now;
   logic ack_on;
   logic [`DRS_FCNT_W-1:0] depth;

   assign depth = `DRS_FCNT_W'(FIFO_DEPTH);

   // Unused field encodings fall back to edge detection.
   always_comb begin
      if (q_ff.mode_field == `DRS_MODE_FIFO16) begin
         mode = dma_req_pkg::MODE_FIFO16;
      end else if (q_ff.mode_field == `DRS_MODE_FIFO1) begin
         mode = dma_req_pkg::MODE_FIFO1;
      end else begin
         mode = dma_req_pkg::MODE_EDGE;
      end
   end

   // A bus clock rising edge, seen only after both synchroniser stages.
   assign tick = q_ff.clk_sync[1] & ~q_ff.clk_prev;
   assign low_now = ~q_ff.req_sync[1];
   // The previous state must already be low, so a one-state glitch is dropped.
   assign level_ok = tick & low_now & q_ff.low_hist[0];
   // A falling edge counts only as high followed by two lows.
   assign edge_det = level_ok & ~q_ff.low_hist[1];
   assign ack_on = (q_ff.ack_st == dma_req_pkg::ACK_HIGH);

   // No address or bus mode input exists here, so sampling cannot depend on them.
   always_comb begin
      if (mode == dma_req_pkg::MODE_EDGE) begin
         grant = q_ff.enable & (q_ff.pending != '0);
      end else begin
         grant = q_ff.enable & (q_ff.fifo_cnt != '0);
      end
   end
   assign XFER_REQ = grant;
   assign confirm = XFER_CONFIRM & grant;
   assign dec = confirm & (mode != dma_req_pkg::MODE_EDGE);

   // The single entry waits until it is emptied, so it never sees up and down together.
   always_comb begin
      inc = 1'b0;
      if (q_ff.enable & level_ok) begin
         if (mode == dma_req_pkg::MODE_FIFO16) begin
            inc = (q_ff.fifo_cnt < depth);
         end else if (mode == dma_req_pkg::MODE_FIFO1) begin
            inc = (q_ff.fifo_cnt == '0) & ~dec;
         end
      end
   end

   // A new edge is taken only once the previous run has counted down to zero; its ack strobe may still be owed.
   assign edge_start = q_ff.enable & (mode == dma_req_pkg::MODE_EDGE) & edge_det
      & (q_ff.pending == '0) & ~q_ff.edge_first;

   // Edge mode acknowledges only its first transfer; FIFO modes each decrement.
   assign ack_req = dec | (confirm & q_ff.edge_first);
   // The single entry raises its strobe together with the decrement.
   assign ack_now = dec & (mode == dma_req_pkg::MODE_FIFO1);

   always_comb begin
      nxt_q = q_ff;
      nxt_q.clk_sync = {q_ff.clk_sync[0], EXT_BUS_CLK};
      nxt_q.req_sync = {q_ff.req_sync[0], EXT_XFER_REQUEST_N};
      nxt_q.clk_prev = q_ff.clk_sync[1];
      nxt_q.rdata = 32'h0;
      if (tick) begin
         nxt_q.low_hist = {q_ff.low_hist[0], low_now};
      end

      // Edge mode run length.
      if (edge_start) begin
         if (q_ff.flag_clear_timing_select | (TRANSFER_COUNT == '0)) begin
            nxt_q.pending = `DRS_CNT_W'(1);
         end else begin
            nxt_q.pending = TRANSFER_COUNT;
         end
         nxt_q.edge_first = 1'b1;
      end else if (confirm & (mode == dma_req_pkg::MODE_EDGE)) begin
         nxt_q.pending = q_ff.pending - `DRS_CNT_W'(1);
         nxt_q.edge_first = 1'b0;
      end

      // Up and down in one cycle leave the count as it was.
      nxt_q.fifo_cnt = q_ff.fifo_cnt + `DRS_FCNT_W'(inc) - `DRS_FCNT_W'(dec);

      // Strobe engine: each strobe ends at the next bus clock tick, so it lasts one bus clock state, or less after a single-entry start.
      case (q_ff.ack_st)
         dma_req_pkg::ACK_IDLE: begin
            if (ack_now) begin
               nxt_q.ack_st = dma_req_pkg::ACK_HIGH;
            end else if (ack_req | (q_ff.ack_owe != '0)) begin
               nxt_q.ack_st = dma_req_pkg::ACK_ARMED;
               nxt_q.ack_owe = q_ff.ack_owe + `DRS_FCNT_W'(ack_req);
            end
         end
         dma_req_pkg::ACK_ARMED: begin
            nxt_q.ack_owe = q_ff.ack_owe + `DRS_FCNT_W'(ack_req);
            if (tick) begin
               nxt_q.ack_st = dma_req_pkg::ACK_HIGH;
               nxt_q.ack_owe = q_ff.ack_owe + `DRS_FCNT_W'(ack_req) - `DRS_FCNT_W'(1);
            end
         end
         dma_req_pkg::ACK_HIGH: begin
            nxt_q.ack_owe = q_ff.ack_owe + `DRS_FCNT_W'(ack_req);
            if (tick) begin
               if ((q_ff.ack_owe != '0) | ack_req) begin
                  nxt_q.ack_st = dma_req_pkg::ACK_ARMED;
               end else begin
                  nxt_q.ack_st = dma_req_pkg::ACK_IDLE;
               end
            end
         end
         default: begin
            nxt_q.ack_st = dma_req_pkg::ACK_IDLE;
         end
      endcase

      // Register port.
      if (REG_WR) begin
         if (REG_ADDR == `DRS_CTRL_OFS) begin
            nxt_q.enable = REG_WDATA[`DRS_CTRL_EN_BIT];
            nxt_q.mode_field = REG_WDATA[`DRS_CTRL_MODE_HI:`DRS_CTRL_MODE_LO];
            nxt_q.flag_clear_timing_select = REG_WDATA[`DRS_CTRL_FCS_BIT];
         end
      end
      if (REG_RD) begin
         if (REG_ADDR == `DRS_CTRL_OFS) begin
            nxt_q.rdata[`DRS_CTRL_EN_BIT] = q_ff.enable;
            nxt_q.rdata[`DRS_CTRL_MODE_HI:`DRS_CTRL_MODE_LO] = q_ff.mode_field;
            nxt_q.rdata[`DRS_CTRL_FCS_BIT] = q_ff.flag_clear_timing_select;
         end else if (REG_ADDR == `DRS_STAT_OFS) begin
            nxt_q.rdata[`DRS_FCNT_W-1:0] = q_ff.fifo_cnt;
            nxt_q.rdata[`DRS_STAT_PEND_BIT] = (q_ff.pending != '0);
            nxt_q.rdata[`DRS_STAT_ACK_BIT] = ~(q_ff.ack_st == dma_req_pkg::ACK_IDLE);
         end
      end

      // A disabled channel forgets every sample; a strobe in flight is cut short.
      if (~q_ff.enable) begin
         nxt_q.low_hist = 2'h0;
         nxt_q.pending = '0;
         nxt_q.edge_first = 1'b0;
         nxt_q.fifo_cnt = '0;
         nxt_q.ack_owe = '0;
         nxt_q.ack_st = dma_req_pkg::ACK_IDLE;
      end
      if (~RSTN) begin
         nxt_q = '0;
         nxt_q.ack_st = dma_req_pkg::ACK_IDLE;
      end
   end

   always_ff @(posedge CLK) begin
      q_ff <= nxt_q;
   end

   assign REQUEST_ACK_STROBE = ack_on;
   assign REG_RDATA = q_ff.rdata;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);


   // The strobe is at most one bus state long.
   // It starts only at a tick or at a single-entry decrement, and ends only at a tick, when the channel is disabled, or at reset.
   a_ack_one_state: assert property (ack_on && tick |=> !ack_on)
      else $error("ack strobe outlived one bus state");

   a_ack_rise_src: assert property (
      $rose(ack_on) |-> $past(tick) || $past(ack_now))
      else $error("ack strobe rose away from a bus clock edge or a decrement");

   a_ack_fall_tick: assert property (
      $fell(ack_on) |-> $past(tick) || !$past(q_ff.enable) || !$past(RSTN))
      else $error("ack strobe fell between bus clock edges");

   // Queue occupancy grows only on a tick, and only while there is room.
   a_fifo_bounded: assert property (q_ff.fifo_cnt <= depth)
      else $error("request queue above its depth");

   a_full_stops: assert property (
      q_ff.enable && mode == dma_req_pkg::MODE_FIFO16 && q_ff.fifo_cnt == depth && !dec
      |=> q_ff.fifo_cnt == depth)
      else $error("full queue changed without a transfer");

   a_updown_hold: assert property (inc && dec |=> $stable(q_ff.fifo_cnt))
      else $error("simultaneous up and down moved the count");

   a_count_moves: assert property (
      q_ff.enable && inc && !dec |=> q_ff.fifo_cnt == $past(q_ff.fifo_cnt) + 5'h1)
      else $error("taken sample not counted");

   a_no_tick_no_sample: assert property (
      q_ff.enable && !tick |=> q_ff.fifo_cnt <= $past(q_ff.fifo_cnt))
      else $error("queue grew without a bus clock edge");

   // Single entry.
   a_single_cap: assert property (
      mode == dma_req_pkg::MODE_FIFO1 && q_ff.enable |-> q_ff.fifo_cnt <= 5'h1)
      else $error("single entry holds more than one sample");

   a_single_ack: assert property (
      q_ff.enable && ack_now && q_ff.ack_st == dma_req_pkg::ACK_IDLE |=> ack_on)
      else $error("single entry ack not raised with decrement");

   a_single_empty: assert property (
      mode == dma_req_pkg::MODE_FIFO1 && dec |=> q_ff.fifo_cnt == '0)
      else $error("single entry refilled in its decrement cycle");

   // Deep queue strobe.
   a_deep_ack_late: assert property (
      q_ff.enable && dec && mode == dma_req_pkg::MODE_FIFO16
      && q_ff.ack_st == dma_req_pkg::ACK_IDLE |=> !ack_on ##[0:100] ack_on)
      else $error("deep queue ack not one state after decrement");

   // Edge runs.
   // The load is checked against the count seen at the start edge, as the input may move later.
   a_edge_busy: assert property (
      edge_det && q_ff.pending != '0 |=> q_ff.pending <= $past(q_ff.pending))
      else $error("edge reloaded a running transfer");

   a_one_per_edge: assert property (edge_start && q_ff.flag_clear_timing_select |=> q_ff.pending == 24'h1)
      else $error("one-per-edge run longer than one");

   a_edge_load: assert property (
      edge_start && !q_ff.flag_clear_timing_select && TRANSFER_COUNT != '0 |=> q_ff.pending == $past(TRANSFER_COUNT))
      else $error("edge run not loaded with the transfer count");

   a_pending_step: assert property (
      confirm && mode == dma_req_pkg::MODE_EDGE |=> q_ff.pending == $past(q_ff.pending) - 24'h1)
      else $error("edge run did not count down by one");

   a_edge_ack: assert property (
      q_ff.enable && confirm && q_ff.edge_first |=> ##[0:100] ack_on)
      else $error("edge run gave no ack");

   a_edge_first_once: assert property (
      confirm && q_ff.edge_first && mode == dma_req_pkg::MODE_EDGE |=> !q_ff.edge_first)
      else $error("edge run asked for a second ack");

   a_glitch_drop: assert property (
      tick && low_now && !q_ff.low_hist[0] |-> !inc && !edge_start)
      else $error("first low state was sampled");

   // Disable and read port.
   // A disabled channel must show no grant at once, and no queue and no strobe from the next cycle.
   a_disable_clears: assert property (
      !q_ff.enable |=> q_ff.fifo_cnt == '0 && q_ff.pending == '0 && !ack_on)
      else $error("disabled channel kept samples or strobe");

   a_no_grant_off: assert property (!q_ff.enable |-> !XFER_REQ)
      else $error("disabled channel requested a transfer");

   a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0)
      else $error("read data stood outside its cycle");

   // Main scenarios.
   c_edge_run: cover property (edge_start && !q_ff.flag_clear_timing_select ##[1:200] q_ff.pending == 24'h1);
   c_fifo_full: cover property (mode == dma_req_pkg::MODE_FIFO16 && q_ff.fifo_cnt == depth);
   c_single_ack: cover property (ack_now ##1 ack_on);
   c_updown: cover property (inc && dec);
   c_edge_busy: cover property (edge_det && q_ff.pending != '0);
endmodule : dma_external_request_sampler
`default_nettype wire

// ### dma_requester_model.sv
// Model of the external device that raises transfer requests on the active-low pin.
`timescale 1ns/10ps
`default_nettype none
module dma_requester_model #(
   // Half period of the bus clock; it stays slower than CLK.
   parameter real HALF_NS = 80.0
) (
   // Pins toward the sampler
   output logic bus_clk,
   output logic req_n,
   input wire logic ack
);
   // Offset by 1 ns so bus clock edges never share a time step with CLK edges.
   initial begin
      bus_clk = 1'b0;
      req_n = 1'b1;
      #1;
      forever #(HALF_NS) bus_clk = ~bus_clk;
   end

   // Holds the pin low for n whole bus states, changing it only on falling bus edges.
   task automatic hold_low(input int n);
      for (int i = 0; i < 40 && ack === 1'b1; i++) @(negedge bus_clk);
      @(negedge bus_clk);
      req_n <= 1'b0;
      repeat (n) @(negedge bus_clk);
      req_n <= 1'b1;
   endtask : hold_low
endmodule : dma_requester_model
`default_nettype wire

// ### tb_dma_external_request_sampler.sv
// Self-checking bench for the external request sampler.
`timescale 1ns/10ps
`default_nettype none
`include "dma_req_params.svh"
module tb_dma_external_request_sampler;
   logic clk;
   logic rstn;
   logic [`DRS_ADDR_W-1:0] addr;
   logic [31:0] wdata;
   logic wr_s;
   logic rd_s;
   logic [31:0] rdata;
   logic bclk;
   logic req_n;
   logic ack;
   logic ack_q = 1'b0;
   logic [`DRS_CNT_W-1:0] tcount;
   logic xreq;
   logic xconf;
   int acks;
   int confirms;
   int mismatches;
   int samples_checked;

   dma_external_request_sampler dma_external_request_sampler_inst (
      .CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s),
      .REG_RD(rd_s), .REG_RDATA(rdata), .EXT_BUS_CLK(bclk), .EXT_XFER_REQUEST_N(req_n),
      .REQUEST_ACK_STROBE(ack), .TRANSFER_COUNT(tcount), .XFER_REQ(xreq),
      .XFER_CONFIRM(xconf));
   dma_requester_model dma_requester_model_inst (.bus_clk(bclk), .req_n(req_n), .ack(ack));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Counts rising edges of the strobe, so a stuck-high strobe counts once only.
   always @(posedge clk) begin
      ack_q <= ack;
      if (ack === 1'b1 && ack_q === 1'b0) begin
         acks++;
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [`DRS_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr

   task automatic rd(input logic [`DRS_ADDR_W-1:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      check(rdata, exp);
   endtask : rd

   // Confirms every owed transfer, one every other cycle, for a fixed window.
   task automatic drain(input int cycles);
      repeat (cycles) begin
         @(posedge clk);
         if (xreq === 1'b1 && xconf === 1'b0) begin
            xconf <= 1'b1;
            confirms++;
         end else begin
            xconf <= 1'b0;
         end
      end
   endtask : drain

   // Confirms in the cycle in which the sampler sees each bus clock rise,
   // so that a taken sample and a confirmed transfer meet in one cycle.
   task automatic confirm_on_ticks(input int n);
      repeat (n) begin
         @(posedge bclk);
         repeat (2) @(posedge clk);
         xconf <= 1'b1;
         confirms++;
         @(posedge clk);
         xconf <= 1'b0;
      end
   endtask : confirm_on_ticks

   task automatic settle_rd_stat(input logic [31:0] exp);
      repeat (100) @(posedge clk);
      rd(`DRS_STAT_OFS, exp);
   endtask : settle_rd_stat

   task automatic end_test(input string name, input int exp_conf, input int exp_acks);
      check(confirms, exp_conf);
      check(acks, exp_acks);
      $display("test %s done", name);
      confirms = 0;
      acks = 0;
   endtask : end_test

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      rstn = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      wr_s = 1'b0;
      rd_s = 1'b0;
      xconf = 1'b0;
      tcount = 24'h000003;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      check({31'h0, xreq}, 32'h0);
      rd(`DRS_CTRL_OFS, 32'h0);
      rd(`DRS_STAT_OFS, 32'h0);
      wr(4'h8, 32'h0000000F);
      rd(4'h8, 32'h0);
      rd(`DRS_CTRL_OFS, 32'h0);
      end_test("reset", 0, 0);
      wr(`DRS_CTRL_OFS, 32'h00000009);
      fork
         dma_requester_model_inst.hold_low(3);
         drain(3000);
      join
      end_test("edge_single", 1, 1);
      wr(`DRS_CTRL_OFS, 32'h00000001);
      fork
         dma_requester_model_inst.hold_low(3);
         drain(3000);
      join
      end_test("edge_count", 3, 1);
      fork
         dma_requester_model_inst.hold_low(1);
         drain(600);
      join
      end_test("edge_glitch", 0, 0);
      // A second edge inside a run must neither reload the count nor add an ack.
      tcount <= 24'h000005;
      dma_requester_model_inst.hold_low(3);
      dma_requester_model_inst.hold_low(3);
      rd(`DRS_STAT_OFS, 32'h00000100);
      drain(3000);
      end_test("edge_busy", 5, 1);
      tcount <= 24'h000000;
      fork
         dma_requester_model_inst.hold_low(3);
         drain(3000);
      join
      end_test("edge_zero", 1, 1);
      wr(`DRS_CTRL_OFS, 32'h00000003);
      dma_requester_model_inst.hold_low(20);
      settle_rd_stat(32'h00000010);
      drain(4000);
      end_test("queue_full", 16, 16);
      fork
         dma_requester_model_inst.hold_low(6);
         drain(3000);
      join
      end_test("queue_flow", 5, 5);
      // Three queued, then three confirms on ticks against two new samples leave two.
      dma_requester_model_inst.hold_low(4);
      settle_rd_stat(32'h00000003);
      fork
         dma_requester_model_inst.hold_low(3);
         confirm_on_ticks(3);
      join
      drain(1500);
      rd(`DRS_STAT_OFS, 32'h0);
      end_test("queue_updown", 5, 5);
      dma_requester_model_inst.hold_low(4);
      settle_rd_stat(32'h00000003);
      wr(`DRS_CTRL_OFS, 32'h00000000);
      rd(`DRS_STAT_OFS, 32'h0);
      drain(500);
      end_test("disable", 0, 0);
      wr(`DRS_CTRL_OFS, 32'h00000003);
      dma_requester_model_inst.hold_low(4);
      settle_rd_stat(32'h00000003);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(`DRS_CTRL_OFS, 32'h0);
      rd(`DRS_STAT_OFS, 32'h0);
      drain(300);
      end_test("reset_mid", 0, 0);
      // Single entry is only meant for bus cycles of two states or more.
      wr(`DRS_CTRL_OFS, 32'h00000005);
      dma_requester_model_inst.hold_low(4);
      settle_rd_stat(32'h00000001);
      drain(1000);
      end_test("single_entry", 1, 1);
      print_verdict();
   end
endmodule : tb_dma_external_request_sampler
`default_nettype wire
